//--- typec_status_cfg.svh
`ifndef TYPEC_STATUS_CFG_SVH
`define TYPEC_STATUS_CFG_SVH

// register offsets on the two-wire port
`define OFS_PORT_SUMMARY 8'h0D
`define OFS_PORT_CONN 8'h0E
`define OFS_CURRENT 8'h10
`define OFS_VOLTAGE 8'h11
`define OFS_TEMP 8'h12

// field positions
`define SUPPLY_BIT 0
`define SINK_BIT 4
`define PIN_LSB 4
`define PIN_MSB 5
`define STATE_LSB 0
`define STATE_MSB 3

// reset values
`define RST_BYTE 8'h00
`define RST_PIN 2'h0
`define RST_STATE 4'h0
`define RST_PTR 8'h00

// output level selection for which the voltage scaling holds
`define VSEL_NOMINAL 3'h0

// pin synchroniser
`define SYNC_STAGES 3
`define BUS_IDLE_LVL 1'h1

`endif

//--- typec_status_pkg.sv
package typec_status_pkg;

  typedef enum logic [3:0] {
    SRC_DISABLED,
    SRC_ERROR_RECOVERY,
    SRC_UNATTACHED,
    SRC_ATTACH_WAIT,
    SRC_ATTACHED_CC1,
    SRC_ATTACHED_CC2
  } source_fsm_state_t;

  typedef struct packed {
    logic supply_applied_flag;
    logic [1:0] active_config_pin;
    source_fsm_state_t source_fsm_state;
  } conn_status_t;

  typedef struct packed {
    logic [7:0] load_current_code;
    logic load_current_valid;
    logic [7:0] load_voltage_code;
    logic load_voltage_valid;
    logic [7:0] die_temp_code;
    logic die_temp_valid;
  } measure_t;

  typedef enum logic [2:0] {
    TW_IDLE,
    TW_ADDR,
    TW_PTR,
    TW_WDATA,
    TW_ACK,
    TW_TX,
    TW_RACK
  } tw_state_t;

endpackage

//--- pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "typec_status_cfg.svh"

module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  //////////////////////////////////////////////////////////////////////////
  // three stages, level moves once stage two and three agree
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= {WIDTH{`BUS_IDLE_LVL}};
      s2_r <= {WIDTH{`BUS_IDLE_LVL}};
      s3_r <= {WIDTH{`BUS_IDLE_LVL}};
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          level_o[g] <= `BUS_IDLE_LVL;
        end else if (s2_r[g] == s3_r[g]) begin
          level_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- typec_status_adc_readout.sv
// How it works
// - bit 0 of summary shows supply applied
// - connection status at 0x0E, writes ignored
// - bits 3:0 report source state machine state
// - current code, eight bits, resets to zero
// - voltage code, scale valid only at select 000
// - temperature code, eight bits, resets to zero
// - summary bit 4 shows sink attached
`timescale 1ns/100ps
`default_nettype none
`include "typec_status_cfg.svh"

module typec_status_adc_readout #(
  // arbitrary bus address
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire typec_status_pkg::conn_status_t conn_i,
  input wire typec_status_pkg::measure_t meas_i,
  input wire logic [2:0] output_level_select_i,
  output logic voltage_scale_nominal_o
);
  import typec_status_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin conditioning
  logic [1:0] bus_lvl;
  logic scl_q;
  logic sda_q;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i({scl_i, sda_i}),
    .level_o(bus_lvl)
  );

  assign scl_q = bus_lvl[1];
  assign sda_q = bus_lvl[0];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d_r <= `BUS_IDLE_LVL;
      sda_d_r <= `BUS_IDLE_LVL;
    end else begin
      scl_d_r <= scl_q;
      sda_d_r <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_d_r;
  assign scl_fall = ~scl_q & scl_d_r;
  assign start_det = scl_q & scl_d_r & sda_d_r & ~sda_q;
  assign stop_det = scl_q & scl_d_r & ~sda_d_r & sda_q;

  //////////////////////////////////////////////////////////////////////////
  // status and measurement registers
  logic [7:0] summary_r;
  logic [7:0] conn_r;
  logic [7:0] current_r;
  logic [7:0] voltage_r;
  logic [7:0] temp_r;
  logic sink_att;

  assign sink_att = (conn_i.source_fsm_state == SRC_ATTACHED_CC1) ||
                    (conn_i.source_fsm_state == SRC_ATTACHED_CC2);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      summary_r <= `RST_BYTE;
    end else begin
      summary_r <= `RST_BYTE;
      summary_r[`SUPPLY_BIT] <= conn_i.supply_applied_flag;
      summary_r[`SINK_BIT] <= sink_att;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conn_r <= `RST_BYTE;
    end else begin
      conn_r <= `RST_BYTE;
      conn_r[`STATE_MSB:`STATE_LSB] <= conn_i.source_fsm_state;
      conn_r[`PIN_MSB:`PIN_LSB] <= conn_i.active_config_pin;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      current_r <= `RST_BYTE;
    end else if (meas_i.load_current_valid) begin
      current_r <= meas_i.load_current_code;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      voltage_r <= `RST_BYTE;
    end else if (meas_i.load_voltage_valid) begin
      voltage_r <= meas_i.load_voltage_code;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      voltage_scale_nominal_o <= 1'b0;
    end else begin
      voltage_scale_nominal_o <= (output_level_select_i == `VSEL_NOMINAL);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      temp_r <= `RST_BYTE;
    end else if (meas_i.die_temp_valid) begin
      temp_r <= meas_i.die_temp_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read multiplexer
  logic [7:0] ptr_r;
  logic [7:0] rd_data;

  always_comb begin
    case (ptr_r)
      `OFS_PORT_SUMMARY: rd_data = summary_r;
      `OFS_PORT_CONN: rd_data = conn_r;
      `OFS_CURRENT: rd_data = current_r;
      `OFS_VOLTAGE: rd_data = voltage_r;
      `OFS_TEMP: rd_data = temp_r;
      default: rd_data = `RST_BYTE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // two-wire target
  tw_state_t state_r;
  tw_state_t after_ack_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= TW_IDLE;
      after_ack_r <= TW_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= `RST_BYTE;
      tx_r <= `RST_BYTE;
      ptr_r <= `RST_PTR;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state_r <= TW_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state_r <= TW_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state_r)
        TW_ADDR, TW_PTR, TW_WDATA: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_q};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (state_r == TW_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                sda_oe_o <= 1'b1;
                state_r <= TW_ACK;
                after_ack_r <= shift_r[0] ? TW_TX : TW_PTR;
              end else begin
                state_r <= TW_IDLE;
              end
            end else if (state_r == TW_PTR) begin
              ptr_r <= shift_r;
              sda_oe_o <= 1'b1;
              state_r <= TW_ACK;
              after_ack_r <= TW_WDATA;
            end else begin
              // data byte dropped, pointer moves on
              ptr_r <= ptr_r + 8'h01;
              sda_oe_o <= 1'b1;
              state_r <= TW_ACK;
              after_ack_r <= TW_WDATA;
            end
          end
        end
        TW_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            state_r <= after_ack_r;
            if (after_ack_r == TW_TX) begin
              tx_r <= rd_data;
              sda_oe_o <= ~rd_data[7];
              ptr_r <= ptr_r + 8'h01;
            end else begin
              sda_oe_o <= 1'b0;
            end
          end
        end
        TW_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              sda_oe_o <= 1'b0;
              state_r <= TW_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_o <= ~tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        TW_RACK: begin
          if (scl_rise) begin
            state_r <= sda_q ? TW_IDLE : TW_ACK;
            after_ack_r <= TW_TX;
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- typec_status_adc_readout_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module typec_status_adc_readout_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire typec_status_pkg::conn_status_t conn_i,
  input wire typec_status_pkg::measure_t meas_i,
  input wire logic [2:0] output_level_select_i,
  input wire logic voltage_scale_nominal_o
);
  import typec_status_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_scale_nominal_on: assert property (
    arst_n_i && output_level_select_i == 3'h0 |=> voltage_scale_nominal_o)
    else $error("scale flag low at select 000");
  chk_scale_nominal_off: assert property (
    output_level_select_i != 3'h0 |=> !voltage_scale_nominal_o)
    else $error("scale flag high at other select");
  chk_scale_rise_cause: assert property (
    $rose(voltage_scale_nominal_o) |-> $past(output_level_select_i) == 3'h0)
    else $error("scale flag rose without cause");
  chk_data_only_low: assert property (
    sda_o == 1'b0)
    else $error("data pin driven high");
  chk_drive_clock_low: assert property (
    $changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed with clock high");
  chk_quiet_after_reset: assert property (
    $rose(arst_n_i) |-> !sda_oe_o [*4])
    else $error("data driven just after reset");
  chk_reset_quiet: assert property (
    disable iff (1'b0) !arst_n_i && $past(!arst_n_i) |->
      !sda_oe_o && !voltage_scale_nominal_o)
    else $error("outputs active in reset");
  chk_idle_after_stop: assert property (
    $rose(sda_i) && scl_i && $past(scl_i) |=> !sda_oe_o [*3])
    else $error("data driven after stop");
endmodule
bind typec_status_adc_readout typec_status_adc_readout_monitor mon (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conn_i(conn_i),
  .meas_i(meas_i), .output_level_select_i(output_level_select_i),
  .voltage_scale_nominal_o(voltage_scale_nominal_o));
`default_nettype wire

//--- tw_host.sv
`timescale 1ns/100ps
`default_nettype none
module tw_host (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // start or repeated start, data set high with clock low, then pulled low while clock is high
  task automatic start();
    hp(2);
    sda_o <= 1'b1;
    hp(8);
    scl_o <= 1'b1;
    hp(8);
    sda_o <= 1'b0;
    hp(8);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    hp(2);
    sda_o <= 1'b0;
    hp(8);
    scl_o <= 1'b1;
    hp(8);
    sda_o <= 1'b1;
    hp(8);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ak,
      output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      hp(2);
      sda_o <= (i > 0) ? tx[i-1] : ak;
      hp(8);
      scl_o <= 1'b1;
      hp(8);
      if (i > 0) rx[i-1] = sda_i;
      else ack = sda_i;
      scl_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- typec_status_adc_readout_bench.sv
`timescale 1ns/100ps
`default_nettype none
module typec_status_adc_readout_bench;
  import typec_status_pkg::*;
  logic ref_clk_i, arst_n_i, scl, hsda, oe, vnom;
  logic [2:0] sel;
  conn_status_t conn;
  measure_t meas;
  logic [7:0] d;
  logic ak;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  // pulled-up open-drain data line
  wire logic sda = hsda & ~oe;
  typec_status_adc_readout #(.DEV_ADDR(7'h2A)) DUT (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
    .conn_i(conn), .meas_i(meas), .output_level_select_i(sel),
    .voltage_scale_nominal_o(vnom));
  tw_host host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
    .sda_o(hsda));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    logic [7:0] x;
    logic a;
    host.start();
    host.byte_io(8'h54, 1'b1, x, a);
    host.byte_io(ofs, 1'b1, x, a);
    host.byte_io(v, 1'b1, x, a);
    check({7'h0, a}, 8'h00);
    host.stop();
  endtask
  task automatic rc(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] x;
    logic a;
    host.start();
    host.byte_io(8'h54, 1'b1, x, a);
    host.byte_io(ofs, 1'b1, x, a);
    host.start();
    host.byte_io(8'h55, 1'b1, x, a);
    host.byte_io(8'hFF, 1'b1, x, a);
    host.stop();
    check(x, exp);
  endtask
  initial begin
    arst_n_i = 1'b0;
    sel = 3'h0;
    conn = '0;
    meas = '0;
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    meas <= '{8'hA5, 1'b0, 8'h3C, 1'b0, 8'h7E, 1'b0};
    repeat (4) @(posedge ref_clk_i);
    rc(8'h10, 8'h00);
    rc(8'h11, 8'h00);
    rc(8'h12, 8'h00);
    @(posedge ref_clk_i);
    meas <= '{8'hA5, 1'b1, 8'h3C, 1'b1, 8'h7E, 1'b1};
    @(posedge ref_clk_i);
    meas <= '{8'h11, 1'b0, 8'h22, 1'b0, 8'h33, 1'b0};
    rc(8'h10, 8'hA5);
    rc(8'h11, 8'h3C);
    rc(8'h12, 8'h7E);
    rc(8'h13, 8'h00);
    // two bytes in one read, pointer moves on by itself
    host.start();
    host.byte_io(8'h54, 1'b1, d, ak);
    host.byte_io(8'h10, 1'b1, d, ak);
    host.start();
    host.byte_io(8'h55, 1'b1, d, ak);
    host.byte_io(8'hFF, 1'b0, d, ak);
    check(d, 8'hA5);
    host.byte_io(8'hFF, 1'b1, d, ak);
    check(d, 8'h3C);
    host.stop();
    // a foreign address is left unanswered
    host.start();
    host.byte_io(8'h56, 1'b1, d, ak);
    check({7'h0, ak}, 8'h01);
    host.stop();
    for (int s = 0; s < 6; s++) begin
      @(posedge ref_clk_i);
      conn <= '{s[0], (s > 3) ? s[1:0] - 2'h3 : 2'h0, source_fsm_state_t'(s)};
      rc(8'h0E, {2'h0, (s > 3) ? s[1:0] - 2'h3 : 2'h0, s[3:0]});
      rc(8'h0D, {3'h0, s > 3, 3'h0, s[0]});
    end
    wr(8'h0E, 8'hFF);
    rc(8'h0E, 8'h25);
    wr(8'h10, 8'h00);
    rc(8'h10, 8'hA5);
    // reset in mid-run clears the current and temperature codes
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rc(8'h10, 8'h00);
    rc(8'h12, 8'h00);
    @(posedge ref_clk_i);
    sel <= 3'h5;
    repeat (3) @(posedge ref_clk_i);
    check({7'h0, vnom}, 8'h00);
    sel <= 3'h0;
    repeat (3) @(posedge ref_clk_i);
    check({7'h0, vnom}, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
